// >>> common/operand_resolver_defs.svh
`ifndef OPERAND_RESOLVER_DEFS_SVH
`define OPERAND_RESOLVER_DEFS_SVH

// highest operand value that is taken as a frame offset
`define OFFSET_LIMIT      8'h5F
// bank reached by the low part of the access bank
`define ACCESS_LOW_BANK   4'h0
// bank reached by the high part of the access bank
`define ACCESS_HIGH_BANK  4'hF
// memory selector values
`define SEL_ACCESS        1'b0
`define SEL_BANKED        1'b1
// result target values
`define DEST_ACC          1'b0
`define DEST_FILE         1'b1
// reset values
`define ADDR_RST          12'h000
`define BYTE_RST          8'h00

`endif

// >>> common/operand_resolver_pkg.sv
package operand_resolver_pkg;

    // sequence idle -> read -> idle, or idle -> read -> write -> idle for an xor; each step flips one bit except write -> idle, which flips both
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11
    } resolver_state_t;

    typedef struct packed {
        resolver_state_t st;
        logic [11:0]     addr;
        logic            rd;
        logic            idx;
        logic            xor_op;
        logic            dest;
        logic [7:0]      acc;
        logic            wr_file;
        logic            wr_acc;
        logic [7:0]      result;
        logic            neg;
        logic            zero;
        logic            done;
    } resolver_regs_t;

endpackage

// >>> logic/file_operand_address_resolver.sv
`timescale 1ns/1ps
`include "operand_resolver_defs.svh"

module file_operand_address_resolver
    import operand_resolver_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    input  wire logic        req_valid_in,
    output logic             req_ready_out,
    input  wire logic [7:0]  operand_in,
    input  wire logic        access_sel_in,
    input  wire logic        dest_sel_in,
    input  wire logic        is_xor_in,
    input  wire logic        ext_set_en_in,
    input  wire logic [3:0]  bank_select_reg_in,
    input  wire logic [11:0] stack_frame_pointer_in,
    input  wire logic [7:0]  accumulator_in,
    input  wire logic [7:0]  file_data_in,
    output logic [11:0]      file_addr_out,
    output logic             file_rd_out,
    output logic             indexed_mode_out,
    output logic [7:0]       result_out,
    output logic             wr_file_out,
    output logic             wr_acc_out,
    output logic             neg_flag_out,
    output logic             zero_flag_out,
    output logic             done_out
);

    resolver_regs_t r_ff;
    resolver_regs_t nxt_r;
    logic           take;
    logic [11:0]    eff_addr;
    logic           use_offset;
    logic [7:0]     xor_val;

    assign req_ready_out = (r_ff.st == ST_IDLE);
    assign take          = req_valid_in && req_ready_out;

    // operand address resolution
    always_comb begin
        use_offset = ext_set_en_in && (access_sel_in == `SEL_ACCESS)
                     && (operand_in <= `OFFSET_LIMIT);
        if (use_offset) begin
            eff_addr = stack_frame_pointer_in + {4'h0, operand_in};
        end else if (access_sel_in == `SEL_BANKED) begin
            eff_addr = {bank_select_reg_in, operand_in};
        end else if (operand_in <= `OFFSET_LIMIT) begin
            eff_addr = {`ACCESS_LOW_BANK, operand_in};
        end else begin
            eff_addr = {`ACCESS_HIGH_BANK, operand_in};
        end
    end

    assign xor_val = r_ff.acc ^ file_data_in;

    // sequencing of request, read and write back
    always_comb begin
        nxt_r         = r_ff;
        nxt_r.rd      = 1'b0;
        nxt_r.wr_file = 1'b0;
        nxt_r.wr_acc  = 1'b0;
        nxt_r.done    = 1'b0;
        unique case (r_ff.st)
            ST_IDLE: begin
                if (take) begin
                    nxt_r.st     = ST_READ;
                    nxt_r.addr   = eff_addr;
                    nxt_r.idx    = use_offset;
                    nxt_r.rd     = 1'b1;
                    nxt_r.xor_op = is_xor_in;
                    nxt_r.dest   = dest_sel_in;
                    nxt_r.acc    = accumulator_in;
                end
            end
            ST_READ: begin
                if (r_ff.xor_op) begin
                    nxt_r.st      = ST_WRITE;
                    nxt_r.result  = xor_val;
                    nxt_r.neg     = xor_val[7];
                    nxt_r.zero    = (xor_val == `BYTE_RST);
                    nxt_r.wr_file = (r_ff.dest == `DEST_FILE);
                    nxt_r.wr_acc  = (r_ff.dest == `DEST_ACC);
                    nxt_r.done    = 1'b1;
                end else begin
                    nxt_r.st   = ST_IDLE;
                    nxt_r.done = 1'b1;
                end
            end
            ST_WRITE: begin
                nxt_r.st = ST_IDLE;
            end
            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            r_ff <= '{st: ST_IDLE, addr: `ADDR_RST, rd: 1'b0, idx: 1'b0, xor_op: 1'b0,
                      dest: 1'b0, acc: `BYTE_RST, wr_file: 1'b0, wr_acc: 1'b0,
                      result: `BYTE_RST, neg: 1'b0, zero: 1'b0, done: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // outputs straight from flops
    assign file_addr_out    = r_ff.addr;
    assign file_rd_out      = r_ff.rd;
    assign indexed_mode_out = r_ff.idx;
    assign result_out       = r_ff.result;
    assign wr_file_out      = r_ff.wr_file;
    assign wr_acc_out       = r_ff.wr_acc;
    assign neg_flag_out     = r_ff.neg;
    assign zero_flag_out    = r_ff.zero;
    assign done_out         = r_ff.done;

    // xor result and destination one cycle after the read
    xor_result_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (r_ff.st == ST_READ && r_ff.xor_op) |=>
            (result_out == ($past(r_ff.acc) ^ $past(file_data_in)))
            && (wr_file_out == $past(r_ff.dest)) && (wr_acc_out != $past(r_ff.dest))
    ) else $error("xor result or destination wrong");

    // banked literal with extension off
    banked_literal_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (take && !ext_set_en_in && access_sel_in) |=>
            file_rd_out && (file_addr_out == {$past(bank_select_reg_in), $past(operand_in)})
    ) else $error("banked literal address wrong");

    // access bank literal with extension off
    access_literal_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (take && !ext_set_en_in && !access_sel_in) |=>
            !indexed_mode_out && (file_addr_out[7:0] == $past(operand_in))
            && (file_addr_out[11:8] == (($past(operand_in) <= `OFFSET_LIMIT)
                ? `ACCESS_LOW_BANK : `ACCESS_HIGH_BANK))
    ) else $error("access literal address wrong");

    // offset mode switched on by the extension
    offset_enable_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        take |=> (indexed_mode_out == $past(ext_set_en_in && !access_sel_in
                                            && (operand_in <= `OFFSET_LIMIT)))
    ) else $error("indexed mode flag wrong");

    // offset added to the frame pointer
    frame_offset_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (take && ext_set_en_in && !access_sel_in && operand_in <= `OFFSET_LIMIT) |=>
            file_addr_out == ($past(stack_frame_pointer_in) + {4'h0, $past(operand_in)})
    ) else $error("frame offset address wrong");

    // zero pointer gives the access bank mapping
    frame_zero_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (take && ext_set_en_in && !access_sel_in && operand_in <= `OFFSET_LIMIT
         && stack_frame_pointer_in == `ADDR_RST) |=>
            file_addr_out == {`ACCESS_LOW_BANK, $past(operand_in)}
    ) else $error("zero pointer mapping wrong");

    // high operands stay literal in extended mode
    high_literal_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (take && ext_set_en_in && !access_sel_in && operand_in > `OFFSET_LIMIT) |=>
            !indexed_mode_out && (file_addr_out == {`ACCESS_HIGH_BANK, $past(operand_in)})
    ) else $error("high operand not literal");

    // read strobe one cycle after take, ready drops
    read_strobe_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        take |=> file_rd_out && !req_ready_out
    ) else $error("read strobe missing after take");

    // read strobe lasts a single cycle
    read_single_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        file_rd_out |=> !file_rd_out
    ) else $error("read strobe longer than one cycle");

    // plain read finishes with no write back
    plain_done_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (r_ff.st == ST_READ && !r_ff.xor_op) |=>
            done_out && req_ready_out && !wr_file_out && !wr_acc_out
    ) else $error("plain read end wrong");

    // xor finishes with flags taken from the new result
    xor_flags_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (r_ff.st == ST_READ && r_ff.xor_op) |=>
            done_out && !req_ready_out && (neg_flag_out == result_out[7])
            && (zero_flag_out == (result_out == `BYTE_RST))
    ) else $error("xor flags or done wrong");

    // write strobes last one cycle and ready returns
    write_once_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_file_out || wr_acc_out) |=> !wr_file_out && !wr_acc_out && req_ready_out
    ) else $error("write strobe longer than one cycle");

    // never both destinations at once
    write_excl_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        !(wr_file_out && wr_acc_out)
    ) else $error("both destinations written");

    // address and mode hold until the next take
    addr_hold_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        !take |=> $stable(file_addr_out) && $stable(indexed_mode_out)
    ) else $error("address changed without a take");

    // result and flags change only after an xor read
    result_hold_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        !(r_ff.st == ST_READ && r_ff.xor_op) |=>
            $stable(result_out) && $stable(neg_flag_out) && $stable(zero_flag_out)
    ) else $error("result changed without an xor");

endmodule // file_operand_address_resolver

// >>> tb/file_operand_address_resolver_tb_top.sv
`timescale 1ns/1ps

module file_operand_address_resolver_tb_top;
    typedef struct packed {
        logic [11:0] addr;
        logic        idx;
        logic        x;
        logic        d;
        logic [7:0]  res;
    } exp_t;

    logic        clk_sys_in, rst_b_in, req_valid_in, req_ready_out;
    logic        access_sel_in, dest_sel_in, is_xor_in, ext_set_en_in;
    logic [3:0]  bank_select_reg_in;
    logic [11:0] stack_frame_pointer_in, file_addr_out;
    logic [7:0]  operand_in, accumulator_in, file_data_in, result_out;
    logic        file_rd_out, indexed_mode_out, wr_file_out, wr_acc_out;
    logic        neg_flag_out, zero_flag_out, done_out;
    int          err_count, n_tests, seed, i, k;
    logic [31:0] r;
    logic [7:0]  f;
    exp_t        e, m;
    exp_t        q[$];

    file_operand_address_resolver dut_u (
        .clk_sys_in             (clk_sys_in),
        .rst_b_in               (rst_b_in),
        .req_valid_in           (req_valid_in),
        .req_ready_out          (req_ready_out),
        .operand_in             (operand_in),
        .access_sel_in          (access_sel_in),
        .dest_sel_in            (dest_sel_in),
        .is_xor_in              (is_xor_in),
        .ext_set_en_in          (ext_set_en_in),
        .bank_select_reg_in     (bank_select_reg_in),
        .stack_frame_pointer_in (stack_frame_pointer_in),
        .accumulator_in         (accumulator_in),
        .file_data_in           (file_data_in),
        .file_addr_out          (file_addr_out),
        .file_rd_out            (file_rd_out),
        .indexed_mode_out       (indexed_mode_out),
        .result_out             (result_out),
        .wr_file_out            (wr_file_out),
        .wr_acc_out             (wr_acc_out),
        .neg_flag_out           (neg_flag_out),
        .zero_flag_out          (zero_flag_out),
        .done_out               (done_out)
    );

    // free running clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // bounded wait for the block to accept a request
    task automatic wait_ready();
        k = 0;
        while (req_ready_out !== 1'b1 && k < 8) begin
            @(negedge clk_sys_in);
            k++;
        end
        if (req_ready_out !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
    endtask

    // results are compared against the oldest note when done pulses
    always @(negedge clk_sys_in) begin
        if (rst_b_in === 1'b1 && done_out === 1'b1) begin
            check(q.size() > 0, 1'b1);
            if (q.size() > 0) m = q.pop_front();
            check(file_addr_out, m.addr);
            check(indexed_mode_out, m.idx);
            check(wr_file_out, m.x & m.d);
            check(wr_acc_out, m.x & ~m.d);
            if (m.x) begin
                check(result_out, m.res);
                check({neg_flag_out, zero_flag_out}, {m.res[7], m.res == 8'h00});
            end
        end
    end

    // reset, then a long run of mixed back-to-back requests
    initial begin
        {req_valid_in, access_sel_in, dest_sel_in, is_xor_in, ext_set_en_in} = 5'h00;
        {bank_select_reg_in, stack_frame_pointer_in, operand_in} = 24'h000000;
        {accumulator_in, file_data_in} = 16'h0000;
        rst_b_in = 1'b0;
        err_count = 0;
        n_tests = 0;
        seed = 32'h64ac;
        repeat (12) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check({file_addr_out, done_out, file_rd_out, req_ready_out}, 15'h0001);
        rst_b_in = 1'b1;
        $display("reset test done");
        for (i = 0; i < 400; i++) begin
            f = (i % 4 == 0) ? 8'h5F : (i % 4 == 1) ? 8'h60 : 8'($random(seed));
            r = $random(seed);
            wait_ready();
            operand_in = f;
            {ext_set_en_in, access_sel_in, dest_sel_in, is_xor_in} = r[3:0];
            bank_select_reg_in = r[7:4];
            stack_frame_pointer_in = (i % 5 == 0) ? 12'h000 : r[31:20];
            accumulator_in = r[15:8];
            req_valid_in = 1'b1;
            e.x = r[0];
            e.d = r[1];
            e.idx = r[3] & ~r[2] & (f <= 8'h5F);
            if (e.idx) e.addr = stack_frame_pointer_in + {4'h0, f};
            else if (r[2]) e.addr = {r[7:4], f};
            else e.addr = {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
            // request stays up while busy with other fields: must be refused
            @(negedge clk_sys_in);
            check({file_rd_out, req_ready_out}, 2'h2);
            operand_in = ~f;
            accumulator_in = ~r[15:8];
            // some reads return the accumulator itself so the zero flag is hit
            file_data_in = (i % 7 == 3) ? r[15:8] : r[23:16];
            e.res = r[15:8] ^ file_data_in;
            q.push_back(e);
            @(negedge clk_sys_in);
            check({file_rd_out, req_ready_out}, {1'b0, ~e.x});
        end
        req_valid_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        check(q.size(), 0);
        $display("random request test done");
        // second reset with an xor in flight: everything clears
        operand_in = 8'hA5;
        {ext_set_en_in, access_sel_in, dest_sel_in, is_xor_in} = 4'h7;
        req_valid_in = 1'b1;
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        rst_b_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        check({file_addr_out, result_out, indexed_mode_out, file_rd_out, done_out}, 23'h000000);
        check({wr_file_out, wr_acc_out, neg_flag_out, zero_flag_out, req_ready_out}, 5'h01);
        rst_b_in = 1'b1;
        // first request right after release is taken
        bank_select_reg_in = 4'hC;
        is_xor_in = 1'b0;
        e = '{addr: 12'hCA5, idx: 1'b0, x: 1'b0, d: 1'b1, res: 8'h00};
        q.push_back(e);
        req_valid_in = 1'b1;
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        check(q.size(), 0);
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule // file_operand_address_resolver_tb_top
